// File: include/svah_pkg.sv
package svah_pkg;
   localparam int MSG_MAX = 32;
   localparam int LEN_W = 6;
   localparam int BYTE_CODE = 0;
   localparam int BYTE_TAG_HI = 2;
   localparam int BYTE_TAG_LO = 3;
   localparam int BYTE_ASYNC_RSVD = 7;
   localparam int BYTE_ROUTE = 8;
   localparam int ROUTE_BYTES = 4;
   localparam int EXTEND_BIT = 7;
   localparam int BYTE_MA_TYPE = 16;
   localparam int BYTE_MA_SUB = 17;
   localparam int BYTE_MA_RSVD = 19;
   localparam int ULP_NUM = 128;
   localparam logic [7:0] ULP_BASE = 8'h80;
   localparam logic [7:0] PRIV_LAST = 8'h11;
   localparam logic [7:0] APP_FIRST = 8'h20;
   localparam logic [7:0] APP_LAST = 8'h23;
   localparam logic [7:0] C_QNODE = 8'h00;
   localparam logic [7:0] C_QNODE_RPL = 8'h01;
   localparam logic [7:0] C_CFG_PORT = 8'h02;
   localparam logic [7:0] C_RESPONSE = 8'h03;
   localparam logic [7:0] C_ASYNC = 8'h04;
   localparam logic [7:0] C_MALERT = 8'h05;
   localparam logic [7:0] C_QUIESCE = 8'h06;
   localparam logic [7:0] C_QPROT = 8'h08;
   localparam logic [7:0] C_QPROT_RPL = 8'h09;
   localparam logic [7:0] C_QPORT = 8'h0A;
   localparam logic [7:0] C_QPORT_RPL = 8'h0B;
   localparam logic [7:0] C_REQ_SAT = 8'h0E;
   localparam logic [7:0] C_REQ_SAT_RPL = 8'h0F;
   localparam logic [LEN_W-1:0] LEN_TAGGED = 6'h04;
   localparam logic [LEN_W-1:0] LEN_ASYNC = 6'h0B;
   localparam logic [LEN_W-1:0] LEN_MALERT = 6'h14;
   localparam logic [7:0] AT_PORT_OPER = 8'h01;
   localparam logic [7:0] AT_ADDR_ERR = 8'h02;
   localparam logic [7:0] AT_LINK_ERP = 8'h03;
   localparam logic [7:0] AT_MASTER_GEN = 8'h04;
   localparam logic [7:0] MS_ALL_NORMAL = 8'h01;
   localparam logic [7:0] MS_NODE_NORMAL = 8'h02;
   localparam logic [7:0] MS_RECONFIG = 8'h03;
   localparam logic [7:0] MS_LINK_NORMAL = 8'h04;

   typedef enum logic [1:0] {
      AL_UNSUP_ULP = 2'h0, AL_UNKNOWN = 2'h1, AL_TOO_SHORT = 2'h2
   } svah_alert_t;
   typedef enum logic [1:0] {
      RC_GOOD = 2'h0, RC_OVERLAP = 2'h1, RC_INV_FIELD = 2'h2
   } svah_ret_t;
   typedef enum logic [3:0] {
      CMD_CONFIG_START = 4'h0, CMD_TERM_IO = 4'h1, CMD_INVALIDATE = 4'h2,
      CMD_STOP_OUT = 4'h3, CMD_QUIESCE = 4'h4, CMD_QUERY_NODE = 4'h5,
      CMD_REISSUE = 4'h6, CMD_GENERAL = 4'h7, CMD_NOTIFY_ALL = 4'h8,
      CMD_NOTIFY_NODE = 4'h9, CMD_CLEAR_TABLE = 4'hA, CMD_RECONFIG = 4'hB,
      CMD_DONE = 4'hF
   } svah_cmd_t;
   typedef enum logic [2:0] {
      K_OTHER = 3'h0, K_PORT_OPER = 3'h1, K_ADDR = 3'h2, K_ERP = 3'h3,
      K_ALL = 3'h4, K_NODE = 3'h5, K_RECONF = 3'h6
   } svah_kind_t;

   typedef struct packed {
      logic [7:0] code;
      logic [15:0] tag;
      logic [LEN_W-1:0] len;
   } svah_info_t;
   typedef struct packed {
      svah_ret_t ret;
      logic [15:0] tag;
      logic [8*ROUTE_BYTES-1:0] route;
   } svah_resp_t;
   typedef struct packed {
      logic known;
      logic frame_priv;
      logic node_ok;
      logic overlap;
      logic rsvd_chk;
      logic [4:0] rsvd_idx;
      logic tag_checked;
      logic data_xfer;
      logic [LEN_W-1:0] min_len;
   } svah_class_t;
endpackage

// File: design/svah_code_class.sv
`timescale 1ns/10ps
module svah_code_class (
   input wire logic [7:0] code_in,
   input wire logic is_cfg_in,
   input wire logic is_master_in,
   output svah_pkg::svah_class_t class_out
);
   always_comb begin
      class_out = '0;
      class_out.min_len = svah_pkg::LEN_TAGGED;
      class_out.frame_priv = (code_in <= svah_pkg::PRIV_LAST);
      class_out.known = class_out.frame_priv ||
         (code_in >= svah_pkg::APP_FIRST && code_in <= svah_pkg::APP_LAST);
      class_out.data_xfer = !class_out.frame_priv && class_out.known;
      class_out.node_ok = 1'b1;
      case (code_in)
         svah_pkg::C_QNODE_RPL, svah_pkg::C_RESPONSE, svah_pkg::C_QPROT_RPL,
         svah_pkg::C_QPORT_RPL, svah_pkg::C_REQ_SAT_RPL: begin
            class_out.node_ok = is_cfg_in;
            class_out.tag_checked = 1'b1;
         end
         svah_pkg::C_REQ_SAT: class_out.node_ok = is_master_in;
         svah_pkg::C_ASYNC: begin
            class_out.node_ok = is_master_in;
            class_out.min_len = svah_pkg::LEN_ASYNC;
            class_out.rsvd_chk = 1'b1;
            class_out.rsvd_idx = 5'(svah_pkg::BYTE_ASYNC_RSVD);
         end
         svah_pkg::C_MALERT: begin
            class_out.node_ok = is_cfg_in;
            class_out.overlap = 1'b1;
            class_out.min_len = svah_pkg::LEN_MALERT;
            class_out.rsvd_chk = 1'b1;
            class_out.rsvd_idx = 5'(svah_pkg::BYTE_MA_RSVD);
         end
         svah_pkg::C_CFG_PORT, svah_pkg::C_QUIESCE, svah_pkg::C_QPROT,
         svah_pkg::C_QPORT: class_out.overlap = 1'b1;
         default: class_out.overlap = 1'b0;
      endcase
      if (class_out.data_xfer) begin
         class_out.tag_checked = 1'b1;
      end
   end
endmodule

// File: design/svah_top.sv
// Operation
// RL1 - code 80h or above with supported protocol goes to that handler, frame unchecked
// RL2 - code 80h or above with unsupported protocol raises unsupported-protocol alert
// RL3 - messages hold at most 32 bytes; pad bytes are ignored
// RL4 - message code is byte 0; 80h and above are upper protocol formats
// RL5 - route field is four bytes; bytes after first clear extend flag ignored
// RL6 - decode 00h-11h and 20h-23h; 12h-1Fh and 24h-7Fh are reserved
// RL7 - invalid code raises unknown-message alert
// RL8 - wrong frame type or wrong node type raises unknown-message alert
// RL9 - repeated outstanding overlap-class message gets overlapped return code
// RL10 - query-node with no room is dropped silently
// RL11 - sender of query-node retries on its own timeout
// RL12 - too few bytes raises message-too-short alert
// RL13 - after an alert the message ends with no other response
// RL14 - nonzero reserved field gets invalid-field response; query-node types exempt
// RL15 - bad tag at configuring node is logged and ignored; data aborts I/O
// RL16 - port operational alert: start configuration, then general handling
// RL17 - address error: terminate, invalidate, general, reissue if alternate path
// RL18 - link recovery exit: invalidate, stop, quiesce all, respond after answers
// RL19 - after quiesce query each node, reissue if link or alternate path
// RL20 - all-normal alert: tell upper layer all nodes ready, then general
// RL21 - node or link normal: withhold reachability until whole path is normal
// RL22 - reconfiguration alert: clear table, reconfigure, then general handling
// RL23 - general handling responds with tag on return route, informs and logs; log_out is not raised for it
// RL24 - code checks, then length, then field; stop at first failure
`timescale 1ns/10ps
module svah_top #(
   parameter int SRC_NUM = 4,
   parameter int SRC_W = 2
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_last_in,
   input wire logic rx_priv_frame_in,
   input wire logic [SRC_W-1:0] rx_src_in,
   input wire logic is_cfg_in,
   input wire logic is_master_in,
   input wire logic [svah_pkg::ULP_NUM-1:0] ulp_support_in,
   input wire logic qnode_room_in,
   input wire logic tag_ok_in,
   input wire logic ovl_clr_in,
   input wire logic [SRC_W-1:0] ovl_clr_src_in,
   input wire logic alt_path_in,
   input wire logic link_cfg_in,
   input wire logic path_normal_in,
   input wire logic act_done_in,
   output logic rx_ready_out,
   output svah_pkg::svah_info_t info_out,
   output logic ulp_valid_out,
   output logic accept_valid_out,
   output logic alert_valid_out,
   output svah_pkg::svah_alert_t alert_code_out,
   output logic resp_valid_out,
   output svah_pkg::svah_resp_t resp_out,
   output logic log_out,
   output logic abort_io_out,
   output logic act_valid_out,
   output svah_pkg::svah_cmd_t act_cmd_out
);
   typedef enum logic [3:0] {
      S_RX = 4'h1, S_CHECK = 4'h2, S_ISSUE = 4'h4, S_WAIT = 4'h8
   } svah_state_t;

   svah_state_t state_reg;
   logic [7:0] msg_reg [svah_pkg::MSG_MAX];
   logic [svah_pkg::LEN_W-1:0] cnt_reg;
   logic [SRC_W-1:0] src_reg, ma_src_reg;
   logic priv_reg;
   logic [SRC_NUM-1:0] outst_reg;
   svah_pkg::svah_kind_t kind_reg, kind;
   svah_pkg::svah_cmd_t cmd_nxt;
   svah_pkg::svah_class_t cls;
   logic [8*svah_pkg::ROUTE_BYTES-1:0] route;
   logic [svah_pkg::ROUTE_BYTES:0] keep;
   logic take, ulp_code, fail_code, fail_ovl, drop_qn, fail_len;
   logic fail_rsvd, fail_tag, ok_all, start_ma;
   assign take = rx_valid_in && rx_ready_out;
   svah_code_class u_class (
      .code_in(info_out.code),
      .is_cfg_in(is_cfg_in),
      .is_master_in(is_master_in),
      .class_out(cls)
   );

   // bytes past the received length read as zero
   function automatic logic [7:0] byte_at(input int idx);
      return (idx < int'(info_out.len)) ? msg_reg[idx] : 8'h00; // RL3
   endfunction
   // route bytes after the first byte with a clear extend flag are dropped
   assign keep[0] = 1'b1;
   for (genvar k = 0; k < svah_pkg::ROUTE_BYTES; k++) begin : g_route
      logic [7:0] rb;
      always_comb rb = byte_at(svah_pkg::BYTE_ROUTE + k);
      assign keep[k+1] = keep[k] && rb[svah_pkg::EXTEND_BIT];
      assign route[8*(svah_pkg::ROUTE_BYTES-k)-1 -: 8] = keep[k] ? rb : 8'h00; // RL5
   end

   // check order: code, length, fields
   assign ulp_code = (info_out.code >= svah_pkg::ULP_BASE); // RL4
   assign fail_code = !cls.known || (cls.frame_priv != priv_reg) || !cls.node_ok; // RL6
   assign fail_ovl = cls.overlap && outst_reg[src_reg]; // RL9
   assign drop_qn = (info_out.code == svah_pkg::C_QNODE) && !qnode_room_in; // RL10
   assign fail_len = info_out.len < cls.min_len; // RL12
   always_comb fail_rsvd = cls.rsvd_chk && (byte_at(int'(cls.rsvd_idx)) != 8'h00); // RL14
   assign fail_tag = cls.tag_checked && is_cfg_in && !tag_ok_in; // RL15
   assign ok_all = !ulp_code && !fail_code && !fail_ovl && !drop_qn && !fail_len &&
      !fail_rsvd && !fail_tag; // RL24
   assign start_ma = ok_all && (info_out.code == svah_pkg::C_MALERT) && is_cfg_in;
   always_comb begin
      kind = svah_pkg::K_OTHER;
      case (byte_at(svah_pkg::BYTE_MA_TYPE))
         svah_pkg::AT_PORT_OPER: kind = svah_pkg::K_PORT_OPER;
         svah_pkg::AT_ADDR_ERR: kind = svah_pkg::K_ADDR;
         svah_pkg::AT_LINK_ERP: kind = svah_pkg::K_ERP;
         svah_pkg::AT_MASTER_GEN: begin
            case (byte_at(svah_pkg::BYTE_MA_SUB))
               svah_pkg::MS_ALL_NORMAL: kind = svah_pkg::K_ALL;
               svah_pkg::MS_NODE_NORMAL, svah_pkg::MS_LINK_NORMAL: kind = svah_pkg::K_NODE;
               svah_pkg::MS_RECONFIG: kind = svah_pkg::K_RECONF;
               default: kind = svah_pkg::K_OTHER;
            endcase
         end
         default: kind = svah_pkg::K_OTHER;
      endcase
   end
   function automatic svah_pkg::svah_cmd_t first_cmd(input svah_pkg::svah_kind_t kd);
      case (kd)
         svah_pkg::K_PORT_OPER: return svah_pkg::CMD_CONFIG_START; // RL16
         svah_pkg::K_ADDR: return svah_pkg::CMD_TERM_IO; // RL17
         svah_pkg::K_ERP: return svah_pkg::CMD_INVALIDATE; // RL18
         svah_pkg::K_ALL: return svah_pkg::CMD_NOTIFY_ALL; // RL20
         svah_pkg::K_NODE: return svah_pkg::CMD_NOTIFY_NODE; // RL21
         svah_pkg::K_RECONF: return svah_pkg::CMD_CLEAR_TABLE; // RL22
         default: return svah_pkg::CMD_GENERAL;
      endcase
   endfunction
   function automatic svah_pkg::svah_cmd_t next_cmd(input svah_pkg::svah_kind_t kd,
         input svah_pkg::svah_cmd_t cur, input logic alt, input logic lcfg);
      case (cur)
         svah_pkg::CMD_TERM_IO: return svah_pkg::CMD_INVALIDATE; // RL17
         svah_pkg::CMD_INVALIDATE: return (kd == svah_pkg::K_ERP) ? // RL18
            svah_pkg::CMD_STOP_OUT : svah_pkg::CMD_GENERAL;
         svah_pkg::CMD_STOP_OUT: return svah_pkg::CMD_QUIESCE; // RL18
         svah_pkg::CMD_CLEAR_TABLE: return svah_pkg::CMD_RECONFIG; // RL22
         svah_pkg::CMD_GENERAL: begin
            if (kd == svah_pkg::K_ERP) begin
               return svah_pkg::CMD_QUERY_NODE; // RL19
            end
            if (kd == svah_pkg::K_ADDR && alt) begin
               return svah_pkg::CMD_REISSUE; // RL17
            end
            return svah_pkg::CMD_DONE;
         end
         svah_pkg::CMD_QUERY_NODE: return (lcfg || alt) ? // RL19
            svah_pkg::CMD_REISSUE : svah_pkg::CMD_DONE;
         svah_pkg::CMD_REISSUE: return svah_pkg::CMD_DONE;
         default: return svah_pkg::CMD_GENERAL;
      endcase
   endfunction
   assign cmd_nxt = next_cmd(kind_reg, act_cmd_out, alt_path_in, link_cfg_in);

   // receive, check and alert sequencing
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= S_RX;
         rx_ready_out <= 1'b1;
         act_cmd_out <= svah_pkg::CMD_DONE;
         kind_reg <= svah_pkg::K_OTHER;
      end else begin
         case (state_reg)
            S_RX: begin
               if (take && rx_last_in) begin
                  state_reg <= S_CHECK;
                  rx_ready_out <= 1'b0;
               end
            end
            S_CHECK: begin
               if (start_ma) begin
                  kind_reg <= kind;
                  act_cmd_out <= first_cmd(kind);
                  state_reg <= S_ISSUE;
               end else begin
                  state_reg <= S_RX;
                  rx_ready_out <= 1'b1;
               end
            end
            S_ISSUE: begin
               if (act_cmd_out != svah_pkg::CMD_NOTIFY_NODE || path_normal_in) begin
                  state_reg <= S_WAIT; // RL21
               end
            end
            S_WAIT: begin
               if (act_done_in) begin
                  act_cmd_out <= cmd_nxt;
                  if (cmd_nxt == svah_pkg::CMD_DONE) begin
                     state_reg <= S_RX;
                     rx_ready_out <= 1'b1;
                  end else begin
                     state_reg <= S_ISSUE;
                  end
               end
            end
            default: begin
               state_reg <= S_RX;
               rx_ready_out <= 1'b1;
            end
         endcase
      end
   end
   // byte capture
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= '0;
         info_out <= '0;
         src_reg <= '0;
         priv_reg <= 1'b0;
      end else if (take) begin
         if (cnt_reg < svah_pkg::LEN_W'(svah_pkg::MSG_MAX)) begin
            cnt_reg <= cnt_reg + 1'b1; // RL3
            info_out.len <= cnt_reg + 1'b1;
            if (cnt_reg == svah_pkg::LEN_W'(svah_pkg::BYTE_CODE)) begin
               info_out.code <= rx_byte_in; // RL4
            end
            if (cnt_reg == svah_pkg::LEN_W'(svah_pkg::BYTE_TAG_HI)) begin
               info_out.tag[15:8] <= rx_byte_in;
            end
            if (cnt_reg == svah_pkg::LEN_W'(svah_pkg::BYTE_TAG_LO)) begin
               info_out.tag[7:0] <= rx_byte_in;
            end
         end
         if (rx_last_in) begin
            cnt_reg <= '0;
            src_reg <= rx_src_in;
            priv_reg <= rx_priv_frame_in;
         end
      end
   end
   always_ff @(posedge clk_in) begin
      if (take && cnt_reg < svah_pkg::LEN_W'(svah_pkg::MSG_MAX)) begin
         msg_reg[cnt_reg[svah_pkg::LEN_W-2:0]] <= rx_byte_in;
      end
   end
   // check outcomes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ulp_valid_out <= 1'b0;
         accept_valid_out <= 1'b0;
         alert_valid_out <= 1'b0;
         alert_code_out <= svah_pkg::AL_UNKNOWN;
         log_out <= 1'b0;
         abort_io_out <= 1'b0;
      end else begin
         ulp_valid_out <= 1'b0;
         accept_valid_out <= 1'b0;
         alert_valid_out <= 1'b0;
         log_out <= 1'b0;
         abort_io_out <= 1'b0;
         if (state_reg == S_CHECK) begin
            if (ulp_code) begin
               if (ulp_support_in[info_out.code[6:0]]) begin
                  ulp_valid_out <= 1'b1; // RL1
               end else begin
                  alert_valid_out <= 1'b1; // RL2
                  alert_code_out <= svah_pkg::AL_UNSUP_ULP;
               end
            end else if (fail_code) begin
               alert_valid_out <= 1'b1; // RL7 RL8 RL13
               alert_code_out <= svah_pkg::AL_UNKNOWN;
            end else if (!fail_ovl && !drop_qn && fail_len) begin
               alert_valid_out <= 1'b1; // RL12 RL13
               alert_code_out <= svah_pkg::AL_TOO_SHORT;
            end else if (!fail_ovl && !drop_qn && !fail_rsvd && fail_tag) begin
               log_out <= 1'b1; // RL15
               abort_io_out <= cls.data_xfer;
            end else if (ok_all) begin
               accept_valid_out <= 1'b1;
            end
         end
      end
   end
   // responses and action strobes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         resp_valid_out <= 1'b0;
         resp_out <= '0;
         act_valid_out <= 1'b0;
      end else begin
         resp_valid_out <= 1'b0;
         act_valid_out <= 1'b0;
         if (state_reg == S_CHECK && !ulp_code && !fail_code) begin
            resp_out.tag <= info_out.tag;
            resp_out.route <= route;
            if (fail_ovl) begin
               resp_valid_out <= 1'b1; // RL9
               resp_out.ret <= svah_pkg::RC_OVERLAP;
            end else if (!drop_qn && !fail_len && fail_rsvd &&
                  info_out.code != svah_pkg::C_QNODE_RPL) begin
               resp_valid_out <= 1'b1; // RL14
               resp_out.ret <= svah_pkg::RC_INV_FIELD;
            end
         end
         if (state_reg == S_ISSUE &&
               (act_cmd_out != svah_pkg::CMD_NOTIFY_NODE || path_normal_in)) begin
            act_valid_out <= 1'b1;
            if (act_cmd_out == svah_pkg::CMD_GENERAL) begin
               resp_valid_out <= 1'b1; // RL23
               resp_out.ret <= svah_pkg::RC_GOOD;
            end
         end
      end
   end
   // overlap bookkeeping per configuring source; set wins over clear
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ma_src_reg <= '0;
      end else if (state_reg == S_CHECK && start_ma) begin
         ma_src_reg <= src_reg;
      end
   end

   for (genvar s = 0; s < SRC_NUM; s++) begin : g_outst
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            outst_reg[s] <= 1'b0;
         end else if (state_reg == S_CHECK && ok_all && cls.overlap &&
               src_reg == SRC_W'(s)) begin
            outst_reg[s] <= 1'b1; // RL9
         end else if ((ovl_clr_in && ovl_clr_src_in == SRC_W'(s)) ||
               (state_reg == S_WAIT && act_done_in && ma_src_reg == SRC_W'(s) &&
               cmd_nxt == svah_pkg::CMD_DONE)) begin
            outst_reg[s] <= 1'b0;
         end
      end
   end
endmodule

// File: verif/svah_props.sv
`timescale 1ns/10ps
module svah_props (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic rx_valid_in,
   input wire logic rx_last_in,
   input wire logic rx_priv_frame_in,
   input wire logic [svah_pkg::ULP_NUM-1:0] ulp_support_in,
   input wire logic qnode_room_in,
   input wire logic rx_ready_out,
   input wire svah_pkg::svah_info_t info_out,
   input wire logic ulp_valid_out,
   input wire logic accept_valid_out,
   input wire logic alert_valid_out,
   input wire svah_pkg::svah_alert_t alert_code_out,
   input wire logic resp_valid_out,
   input wire svah_pkg::svah_resp_t resp_out,
   input wire logic log_out,
   input wire logic act_valid_out,
   input wire svah_pkg::svah_cmd_t act_cmd_out
);
   logic any_w;
   assign any_w = ulp_valid_out | accept_valid_out | alert_valid_out | resp_valid_out | log_out;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence last_s;
      rx_valid_in && rx_ready_out && rx_last_in;
   endsequence
   sequence ulp_s;
      last_s ##1 info_out.code >= svah_pkg::ULP_BASE;
   endsequence
   ready_drop_a: assert property (last_s |=> !rx_ready_out)
      else $error("ready held");
   ulp_pass_a: assert property (ulp_s ##0 ulp_support_in[info_out.code[6:0]] |-> ##1 ulp_valid_out)
      else $error("protocol not passed");
   ulp_unsup_a: assert property (ulp_s ##0 !ulp_support_in[info_out.code[6:0]] |->
      ##1 alert_valid_out && alert_code_out == svah_pkg::AL_UNSUP_ULP)
      else $error("no unsupported alert");
   rsvd_code_a: assert property (last_s ##1 info_out.code inside {[8'h12:8'h1F], [8'h24:8'h7F]}
      |-> ##1 alert_valid_out && alert_code_out == svah_pkg::AL_UNKNOWN)
      else $error("reserved code not alerted");
   alert_alone_a: assert property (alert_valid_out |-> any_w == alert_valid_out && !resp_valid_out)
      else $error("alert not alone");
   qnode_drop_a: assert property (last_s ##0 rx_priv_frame_in ##1
      info_out.code == svah_pkg::C_QNODE && !qnode_room_in |-> ##1 !any_w)
      else $error("dropped query answered");
   general_resp_a: assert property (act_valid_out && act_cmd_out == svah_pkg::CMD_GENERAL
      |-> ##[0:1] resp_valid_out && resp_out.ret == svah_pkg::RC_GOOD)
      else $error("general without response");
   answer_time_a: assert property ((ulp_valid_out || alert_valid_out)
      |-> $past(rx_valid_in && rx_ready_out && rx_last_in, 2))
      else $error("answer timing wrong");
endmodule
bind svah_top svah_props svah_props_i (.*);

// File: verif/svah_peer.sv
`timescale 1ns/10ps
module svah_peer (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic act_valid_in,
   input wire logic slow_in,
   output logic act_done_out
);
   logic [3:0] wait_reg;
   logic busy_reg;
   // done pulses the cycle after the action strobe is taken, or nine cycles later when slow_in is set; no replies are modelled
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_reg <= 1'b0;
         wait_reg <= 4'h0;
         act_done_out <= 1'b0;
      end else begin
         act_done_out <= 1'b0;
         if (act_valid_in) begin
            busy_reg <= 1'b1;
            wait_reg <= slow_in ? 4'h9 : 4'h0;
         end else if (busy_reg && wait_reg == 4'h0) begin
            busy_reg <= 1'b0;
            act_done_out <= 1'b1;
         end else if (busy_reg) begin
            wait_reg <= wait_reg - 4'h1;
         end
      end
   end
endmodule

// File: verif/svah_bench.sv
`timescale 1ns/10ps
module svah_bench;
   logic clk_in = 1'b0, rst_n_in = 1'b0, rx_valid_in = 1'b0, rx_last_in = 1'b0;
   logic rx_priv_frame_in = 1'b1, is_cfg_in = 1'b1, is_master_in = 1'b0, qnode_room_in = 1'b1;
   logic tag_ok_in = 1'b1, ovl_clr_in = 1'b0, alt_path_in = 1'b1, link_cfg_in = 1'b1;
   logic path_normal_in = 1'b1, slow = 1'b0, act_done_in;
   logic [7:0] rx_byte_in = 8'h00;
   logic [1:0] rx_src_in = 2'h0, ovl_clr_src_in = 2'h0;
   logic [127:0] ulp_support_in = 128'h0;
   logic rx_ready_out, ulp_valid_out, accept_valid_out, alert_valid_out, resp_valid_out;
   logic log_out, abort_io_out, act_valid_out;
   svah_pkg::svah_info_t info_out;
   svah_pkg::svah_alert_t alert_code_out;
   svah_pkg::svah_resp_t resp_out, gresp;
   svah_pkg::svah_cmd_t act_cmd_out;
   logic [3:0] acts[$];
   logic [7:0] m[$];
   integer n_mismatch = 0, checks = 0, seed = 28946, i, j, k;
   int ovl[4] = '{0, 0, 0, 0};
   always #10 clk_in = ~clk_in;
   svah_top svah_top_i (.*);
   svah_peer svah_peer_i (.clk_in, .rst_n_in, .act_valid_in(act_valid_out), .slow_in(slow),
      .act_done_out(act_done_in));
   always @(posedge clk_in) begin
      if (act_valid_out === 1'b1) acts.push_back(act_cmd_out);
      if (resp_valid_out === 1'b1) gresp = resp_out;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task complete_run();
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // 0 none, 1 passed on, 2..4 alert, 5 overlap, 6 bad field, 7 logged, 8 accepted
   function automatic int model(input logic pf, input logic [1:0] src);
      int c = m[0];
      if (c >= 128) return ulp_support_in[c - 128] ? 1 : 2;
      if (c inside {[18:31], [36:127]} || c == 4 || pf !== (c < 32)) return 3;
      if (c inside {2, 5, 6, 8, 10} && ovl[src] != 0) return 5;
      if (c == 0 && qnode_room_in == 1'b0) return 0;
      if (m.size() < (c == 5 ? 20 : 4)) return 4;
      if (c == 5 && m[19] != 8'h00) return 6;
      if (c >= 32 && tag_ok_in == 1'b0) return 7;
      if (c inside {2, 5, 6, 8, 10}) ovl[src] = 1;
      return 8;
   endfunction
   function automatic int outcome();
      if (ulp_valid_out === 1'b1) return 1;
      if (alert_valid_out === 1'b1) return 2 + alert_code_out;
      if (resp_valid_out === 1'b1) return resp_out.ret == svah_pkg::RC_OVERLAP ? 5 : 6;
      if (log_out === 1'b1) return 7;
      return accept_valid_out === 1'b1 ? 8 : 0;
   endfunction
   task automatic mk(input logic [7:0] c, input int n);
      m = {};
      for (i = 0; i < n; i++) m.push_back(i == 0 ? c : i inside {2, 3} ? 8'($random(seed)) : 8'h00);
   endtask
   task automatic send(input logic pf, input logic [1:0] src);
      for (j = 0; j < 100 && rx_ready_out !== 1'b1; j++) @(negedge clk_in);
      foreach (m[b]) begin
         @(negedge clk_in);
         rx_valid_in = 1'b1;
         rx_byte_in = m[b];
         rx_last_in = (b == m.size() - 1);
         rx_priv_frame_in = pf;
         rx_src_in = src;
      end
      @(negedge clk_in);
      rx_valid_in = 1'b0;
      rx_byte_in = ~rx_byte_in;
      rx_last_in = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic go(input logic pf, input logic [1:0] src);
      int e = model(pf, src);
      send(pf, src);
      chk(outcome(), e);
   endtask
   task automatic run(input logic [7:0] c, input int n, input logic pf, input logic [1:0] src);
      mk(c, n);
      go(pf, src);
   endtask
   task automatic ma(input logic [7:0] ty, input logic [7:0] sb, input logic [23:0] sq);
      logic [31:0] rt = {8'h80 | 8'($random(seed)), 8'h7F & 8'($random(seed)), 16'($random(seed))};
      mk(8'h05, 20);
      for (i = 0; i < 4; i++) m[8 + i] = rt[31 - 8 * i -: 8];
      m[16] = ty;
      m[17] = sb;
      acts = {};
      slow = 1'($random(seed));
      path_normal_in = sq[23:20] != 4'h9;
      send(1'b1, 2'h1);
      if (!path_normal_in) begin
         repeat (10) @(negedge clk_in);
         chk(acts.size(), 0);
         path_normal_in = 1'b1;
      end
      for (j = 0; j < 3000 && rx_ready_out !== 1'b1; j++) @(negedge clk_in);
      for (i = 0; i < 6; i++) if (sq[23 - 4 * i -: 4] != 4'hF) chk(acts[i], sq[23 - 4 * i -: 4]);
      chk(gresp, {svah_pkg::RC_GOOD, m[2], m[3], rt[31:16], 16'h0000});
   endtask
   initial begin
      ulp_support_in = {$random(seed), $random(seed), $random(seed), $random(seed)};
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'b1;
      for (k = 0; k < 12; k++) run(8'h80 | 8'($random(seed)), 1 + 2 * k, k[0], 2'h0);
      for (k = 0; k < 8; k++) run(k[0] ? 8'h12 + 8'($random(seed) & 7) : 8'h24 + 8'($random(seed) & 63), 4, k[1], 2'h0);
      run(8'h1F, 2, 1'b1, 2'h0);
      run(8'h7F, 2, 1'b0, 2'h0);
      run(8'h04, 12, 1'b1, 2'h0);
      run(8'h20, 8, 1'b1, 2'h0);
      run(8'h02, 32, 1'b1, 2'h2);
      run(8'h02, 4, 1'b1, 2'h2);
      run(8'h06, 4, 1'b1, 2'h3);
      @(negedge clk_in);
      ovl_clr_in = 1'b1;
      ovl_clr_src_in = 2'h2;
      ovl[2] = 0;
      @(negedge clk_in);
      ovl_clr_in = 1'b0;
      run(8'h02, 3, 1'b1, 2'h2);
      qnode_room_in = 1'b0;
      run(8'h00, 4, 1'b1, 2'h0);
      qnode_room_in = 1'b1;
      run(8'h00, 4, 1'b1, 2'h0);
      mk(8'h05, 20);
      m[19] = 8'h5A;
      go(1'b1, 2'h0);
      tag_ok_in = 1'b0;
      run(8'h21, 4, 1'b0, 2'h0);
      chk(abort_io_out, 1'b1);
      tag_ok_in = 1'b1;
      ma(svah_pkg::AT_PORT_OPER, 8'h00, 24'h07FFFF);
      ma(svah_pkg::AT_ADDR_ERR, 8'h00, 24'h1276FF);
      alt_path_in = 1'b0;
      ma(svah_pkg::AT_ADDR_ERR, 8'h00, 24'h127FFF);
      alt_path_in = 1'b1;
      ma(svah_pkg::AT_LINK_ERP, 8'h00, 24'h234756);
      ma(svah_pkg::AT_MASTER_GEN, svah_pkg::MS_ALL_NORMAL, 24'h87FFFF);
      ma(svah_pkg::AT_MASTER_GEN, svah_pkg::MS_NODE_NORMAL, 24'h97FFFF);
      ma(svah_pkg::AT_MASTER_GEN, svah_pkg::MS_RECONFIG, 24'hAB7FFF);
      ma(svah_pkg::AT_MASTER_GEN, svah_pkg::MS_LINK_NORMAL, 24'h97FFFF);
      complete_run();
   end
   initial begin
      #(20 * 40000);
      n_mismatch = n_mismatch + 1;
      complete_run();
   end
endmodule
